/* common/pdt_defs.vh */
// Constants for the prescaled down timer
`ifndef PDT_DEFS_VH
`define PDT_DEFS_VH

`define PDT_ADDR_PRESCALER 8'hd2
`define PDT_ADDR_COUNT 8'hd3
`define PDT_ADDR_CTRL 8'hd4

`define PDT_COUNT_RST 8'hff
`define PDT_PRESC_RST 7'h7f
`define PDT_CTRL_RST 8'h00
`define PDT_ZERO 8'h00

`define PDT_BIT_ZERO 7
`define PDT_BIT_IRQEN 6
`define PDT_BIT_DIR 5
`define PDT_BIT_VALGATE 4
`define PDT_BIT_RUN 3

`define PDT_DIV12 4'hb
`define PDT_DIV_ZERO 4'h0

`endif

/* design/pdt_timer.v */
// Prescaled down timer with prescaler, counter, control/status and timer pin
`timescale 1ns/100ps
`include "pdt_defs.vh"

module pdt_timer #(
   parameter PRESC_W = 7,
   parameter COUNT_W = 8
) (
   input wire i_clk, // Core clock, 40 MHz
   input wire i_rst_n, // Async reset, active low
   input wire [7:0] i_addr, // Data-space address
   input wire [7:0] i_wdata, // Write data
   input wire i_wr, // Write strobe, one cycle
   input wire i_rd, // Read strobe
   input wire i_pin_in, // Timer pin level
   output reg [7:0] o_rdata, // Read data, registered
   output reg o_pin_out, // Timer pin drive value
   output reg o_pin_oe, // Timer pin drive enable
   output reg o_irq, // Timer interrupt request, vector 3
   output reg o_wake // Wake request from wait state
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg [PRESC_W-1:0] prescaler_state;
   reg [COUNT_W-1:0] count_value;
   reg [7:0] timer_control_status;
   reg [3:0] div12_cnt;
   reg div12_tick;
   reg pin_q;
   reg tap_q;
   reg out_latch;

   wire zero_reached_flag = timer_control_status[`PDT_BIT_ZERO];
   wire zero_irq_enable = timer_control_status[`PDT_BIT_IRQEN];
   wire pin_direction_sel = timer_control_status[`PDT_BIT_DIR];
   wire pin_value_or_gate_sel = timer_control_status[`PDT_BIT_VALGATE];
   wire prescale_run = timer_control_status[`PDT_BIT_RUN];
   wire [2:0] tap_select = timer_control_status[2:0];

   wire wr_presc = i_wr && (i_addr == `PDT_ADDR_PRESCALER);
   wire wr_count = i_wr && (i_addr == `PDT_ADDR_COUNT);
   wire wr_ctrl = i_wr && (i_addr == `PDT_ADDR_CTRL);

   // ------------------------------------------------------------
   // Prescaler input source
   // ------------------------------------------------------------
   // Pin edge detection limits event rate to a fraction of core clock
   wire pin_rise = i_pin_in && !pin_q;
   reg presc_tick;
   always @* begin
      if (pin_direction_sel)
         presc_tick = div12_tick; // output mode uses core/12
      else if (pin_value_or_gate_sel)
         presc_tick = div12_tick && i_pin_in; // gate on pin high
      else
         presc_tick = pin_rise; // event counting
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div12_cnt <= `PDT_DIV_ZERO;
         div12_tick <= 1'b0;
         pin_q <= 1'b0;
      end else begin
         pin_q <= i_pin_in;
         div12_tick <= (div12_cnt == `PDT_DIV12);
         if (div12_cnt == `PDT_DIV12)
            div12_cnt <= `PDT_DIV_ZERO;
         else
            div12_cnt <= div12_cnt + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // Tap multiplexer
   // ------------------------------------------------------------
   // Divide-by-1 tap behaves as a pulse; others as level rising edges
   wire [PRESC_W-1:0] presc_dec = prescaler_state - {{(PRESC_W-1){1'b0}}, 1'b1};
   wire [PRESC_W:0] taps = {prescaler_state, 1'b0};
   wire tap_lvl = taps[tap_select];
   wire tap_rise = (tap_select == 3'h0) ? presc_tick : (tap_lvl && !tap_q);
   wire count_tick = prescale_run && tap_rise;
   wire [COUNT_W-1:0] count_dec = count_value - {{(COUNT_W-1){1'b0}}, 1'b1};
   wire dec_to_zero = count_tick && (count_dec == `PDT_ZERO);

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prescaler_state <= `PDT_PRESC_RST;
         tap_q <= 1'b1;
      end else begin
         tap_q <= tap_lvl;
         // forced to all ones when stopped
         if (!prescale_run)
            prescaler_state <= `PDT_PRESC_RST;
         else if (wr_presc)
            prescaler_state <= i_wdata[PRESC_W-1:0];
         else if (presc_tick)
            prescaler_state <= presc_dec;
      end
   end

   // ------------------------------------------------------------
   // Counter and control/status
   // ------------------------------------------------------------
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_value <= `PDT_COUNT_RST;
         timer_control_status <= `PDT_CTRL_RST;
      end else begin
         if (wr_count)
            count_value <= i_wdata[COUNT_W-1:0];
         else if (count_tick)
            count_value <= count_dec;
         if (wr_ctrl)
            timer_control_status <= i_wdata;
         // zero write sets flag; set beats clear
         if (wr_count && (i_wdata == `PDT_ZERO))
            timer_control_status[`PDT_BIT_ZERO] <= 1'b1;
         // decrement to zero unless a count write coincides
         else if (dec_to_zero && !wr_count)
            timer_control_status[`PDT_BIT_ZERO] <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         out_latch <= 1'b0;
         o_pin_out <= 1'b0;
         o_pin_oe <= 1'b0;
         o_irq <= 1'b0;
         o_wake <= 1'b0;
         o_rdata <= 8'h00;
      end else begin
         if (zero_reached_flag)
            out_latch <= pin_value_or_gate_sel;
         o_pin_out <= out_latch;
         o_pin_oe <= pin_direction_sel;
         o_irq <= zero_reached_flag && zero_irq_enable;
         o_wake <= zero_reached_flag && zero_irq_enable;
         if (i_rd) begin
            case (i_addr)
               `PDT_ADDR_PRESCALER: o_rdata <= {1'b0, prescaler_state};
               `PDT_ADDR_COUNT: o_rdata <= count_value;
               `PDT_ADDR_CTRL: o_rdata <= timer_control_status;
               default: o_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule

/* tb/pdt_props.sv */
// Port assertions for the prescaled down timer
`timescale 1ns/100ps
module pdt_props (
   input wire i_clk, input wire i_rst_n, input wire [7:0] i_addr, input wire [7:0] i_wdata,
   input wire i_wr, input wire i_rd, input wire i_pin_in, input wire [7:0] o_rdata,
   input wire o_pin_out, input wire o_pin_oe, input wire o_irq, input wire o_wake);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire cw = i_wr && i_addr == 8'hd4;
   wire rp = i_rd && !i_wr && i_addr == 8'hd2;
   a_wake_irq: assert property (o_wake == o_irq) else $error("wake");
   a_irq_set: assert property (cw && i_wdata[7:6] == 2'h3 ##1 !i_wr |=> o_irq)
      else $error("irq");
   a_irq_off: assert property (cw && !i_wdata[6] ##1 !i_wr |=> !o_irq)
      else $error("irq off");
   a_oe_dir: assert property (cw ##1 !cw |=> o_pin_oe == $past(i_wdata[5], 2))
      else $error("oe");
   a_rd_unmap: assert property (i_rd && (i_addr < 8'hd2 || i_addr > 8'hd4) |=> !o_rdata)
      else $error("unmap");
   a_rd_hold: assert property (!i_rd |=> $stable(o_rdata)) else $error("hold");
   a_presc_7b: assert property (rp |=> !o_rdata[7]) else $error("msb");
   a_stop_presc: assert property (cw && !i_wdata[3] ##1 !i_wr ##1 rp |=> o_rdata == 8'h7f)
      else $error("stop");
   a_cnt_load: assert property (i_wr && i_addr == 8'hd3 ##1 i_rd && !i_wr && i_addr == 8'hd3
      |=> o_rdata == $past(i_wdata, 2)) else $error("load");
   c_irq: cover property ($rose(o_irq));
   c_pin: cover property (o_pin_oe && o_pin_out);
   c_load: cover property (i_wr && i_addr == 8'hd3 ##1 i_rd);
endmodule
bind pdt_timer pdt_props u_props (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
   .i_pin_in, .o_rdata, .o_pin_out, .o_pin_oe, .o_irq, .o_wake);

/* tb/pdt_pin_src.sv */
// Signal source on the timer pin
`timescale 1ns/100ps
module pdt_pin_src (
   input wire i_clk, // Core clock
   input wire [1:0] i_mode, // 0 low, 1 high, 2 slow pulses
   output reg o_pin // Pin level
);
   reg [3:0] div;
   initial begin
      div = 4'h0;
      o_pin = 1'b0;
   end
   // edges well below a quarter rate
   always @(posedge i_clk) begin
      div <= div + 4'h1;
      o_pin <= (i_mode == 2'h2) ? div[3] : i_mode[0];
   end
endmodule

/* tb/tb.sv */
// Self-checking bench for the prescaled down timer
`timescale 1ns/100ps
module tb;
   reg clk, rst_n, wr, rd;
   reg [7:0] addr, wdata, v, r;
   reg [1:0] mode;
   wire [7:0] rdata;
   wire src, pout, poe, irq, wake;
   integer bad_count, comparisons, i;
   pdt_timer DUT (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .i_pin_in(poe ? pout : src), .o_rdata(rdata), .o_pin_out(pout),
      .o_pin_oe(poe), .o_irq(irq), .o_wake(wake));
   pdt_pin_src u_src (.i_clk(clk), .i_mode(mode), .o_pin(src));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task chk(input [7:0] got, input [7:0] exp); begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   end endtask
   task tick(input integer n); begin
      repeat (n) @(posedge clk);
      #1;
   end endtask
   task wrt(input [7:0] a, input [7:0] d); begin
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
   end endtask
   task rdc(input [7:0] a); begin
      addr = a;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      r = rdata;
   end endtask
   task results; begin
      if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   end endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {bad_count, comparisons, wr, rd, addr, wdata, mode, rst_n} = 0;
      v = $urandom(32'h2e52);
      tick(20);
      rst_n = 1'b1;
      rdc(8'hd2); chk(r, 8'h7f);
      tick(1); rdc(8'hd3); chk(r, 8'hff);
      tick(1); rdc(8'hd4); chk(r, 8'h00);
      wrt(8'hd2, 8'h15); tick(1); wrt(8'hd4, 8'h00); tick(1);
      rdc(8'hd2); chk(r, 8'h7f);
      wrt(8'hd4, 8'h08);
      for (i = 0; i < 8; i = i + 1) begin
         v = $urandom;
         wrt(8'hd3, v); rdc(8'hd3); chk(r, v);
         wrt(8'hd2, v & 8'h7f); rdc(8'hd2); chk(r, v & 8'h7f);
      end
      tick(40); rdc(8'hd3); chk(r, v);
      wrt(8'hd4, 8'h18); tick(40); rdc(8'hd3); chk(r, v);
      wrt(8'hd4, 8'h28); tick(1); wrt(8'hd3, 8'h02);
      i = 0;
      r = 8'h00;
      addr = 8'hd4;
      rd = 1'b1;
      while (!r[7]) begin
         tick(1);
         r = rdata;
         i = i + 1;
         if (i > 200) begin
            bad_count = bad_count + 1;
            results;
         end
      end
      rd = 1'b0;
      chk({7'h0, i >= 12 && i <= 40}, 8'h01);
      tick(1); rdc(8'hd3); chk(r, 8'h00);
      wrt(8'hd4, 8'hb8); tick(3); chk({7'h0, pout}, 8'h01);
      wrt(8'hd4, 8'h28); tick(3); chk({6'h0, poe, pout}, 8'h03);
      wrt(8'hd4, 8'hc8); tick(2); chk({6'h0, wake, irq}, 8'h03);
      wrt(8'hd4, 8'h48); tick(2); chk({7'h0, irq}, 8'h00);
      wrt(8'hd3, 8'h00); tick(2); chk({7'h0, irq}, 8'h01);
      wrt(8'hd4, 8'h08); mode = 2'h2; tick(1); wrt(8'hd3, 8'h50); tick(100);
      rdc(8'hd3); chk({7'h0, r < 8'h50 && r > 8'h48}, 8'h01);
      wrt(8'hd4, 8'h09); tick(1); wrt(8'hd3, 8'h50); tick(200);
      rdc(8'hd3); chk({7'h0, r <= 8'h4b && r >= 8'h48}, 8'h01);
      results;
   end
endmodule
